// ==== common/mrx_defines.svh ====
// constants for the move-and-return execution block
// assumes a 14-bit program word, 13-bit program counter, 7-bit file address
//
// Functional notes
// - the store-accumulator instruction writes the accumulator to the 7-bit file address 0..127 and touches no flag.
// - the load-literal instruction puts its 8-bit literal into the accumulator and touches no flag.
// - the interrupt-return instruction pops the stack and loads the popped top into the program counter.
// - the interrupt-return instruction also sets the global interrupt enable, bit 7 of the interrupt control register, and touches no flag.
// - the interrupt-return instruction is one word and takes two instruction cycles.
// - the literal-return instruction puts its 8-bit literal into the accumulator and touches no flag.
// - the literal-return instruction pops the stack and loads the return address into the program counter.
// - the literal-return instruction takes two instruction cycles.
`ifndef MRX_DEFINES_SVH
`define MRX_DEFINES_SVH

`define MRX_WORD_W        14
`define MRX_PC_W          13
`define MRX_DATA_W        8
`define MRX_FADDR_W       7
`define MRX_STACK_DEPTH   8
`define MRX_STACK_PTR_W   3
`define MRX_GIE_BIT       7

// opcode fields
`define MRX_OP_MOVE_MASK  14'h3f80
`define MRX_OP_STORE_ACC  14'h0080
`define MRX_OP_NOP_MASK   14'h3f9f
`define MRX_OP_NOP        14'h0000
`define MRX_OP_IRET       14'h0009
`define MRX_OP_LIT_MASK   14'h3c00
`define MRX_OP_LOAD_LIT   14'h3000
`define MRX_OP_LIT_RET    14'h3400

// reset values
`define MRX_PC_RST        13'h0000
`define MRX_ACC_RST       8'h00
`define MRX_IRQ_CTRL_RST  8'h00

`endif

// ==== common/mrx_pkg.sv ====
// types shared by the execution block and its stack
// assumes mrx_defines.svh is on the include path
`include "mrx_defines.svh"

package mrx_pkg;
    typedef logic [`MRX_WORD_W-1:0]  mrx_word_t;
    typedef logic [`MRX_PC_W-1:0]    mrx_pc_t;
    typedef logic [`MRX_DATA_W-1:0]  mrx_data_t;
    typedef logic [`MRX_FADDR_W-1:0] mrx_faddr_t;

    typedef enum logic [2:0] {
        MRX_OP_STORE,
        MRX_OP_LOAD,
        MRX_OP_NONE,
        MRX_OP_IRET,
        MRX_OP_LRET,
        MRX_OP_OTHER
    } mrx_op_t;

    typedef enum logic {
        MRX_ST_EXEC,
        MRX_ST_SECOND
    } mrx_state_t;
endpackage

// ==== common/mrx_stack_if.sv ====
// carrier between the executor and its return-address stack
// assumes both ends share clk
`timescale 1ns/1ps
`include "mrx_defines.svh"

interface mrx_stack_if;
    logic            push;
    logic            pop;
    mrx_pkg::mrx_pc_t push_data;
    mrx_pkg::mrx_pc_t top;

    modport core (output push, output pop, output push_data, input top);
    modport mem  (input push, input pop, input push_data, output top);
endinterface

// ==== verilog/mrx_stack.sv ====
// circular return-address stack with a registered top-of-stack
// assumes push and pop never arrive together; push takes priority
`timescale 1ns/1ps
`include "mrx_defines.svh"

module mrx_stack (
    input wire logic    clk,
    input wire logic    rst_b,
    input wire logic    ce,
    mrx_stack_if.mem    stk
);
    mrx_pkg::mrx_pc_t                 mem_reg [`MRX_STACK_DEPTH];
    logic [`MRX_STACK_PTR_W-1:0]      ptr_reg;

    function automatic logic [`MRX_STACK_PTR_W-1:0] ptr_back(
        input logic [`MRX_STACK_PTR_W-1:0] p,
        input logic [`MRX_STACK_PTR_W-1:0] n
    );
        ptr_back = p - n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // overflow wraps and overwrites the oldest entry, as a fixed stack does
    always_ff @(posedge clk) begin
        if (ce && stk.push) begin
            mem_reg[ptr_reg] <= stk.push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ptr_reg <= '0;
        end else if (ce && stk.push) begin
            ptr_reg <= ptr_reg + 3'h1;
        end else if (ce && stk.pop) begin
            ptr_reg <= ptr_back(ptr_reg, 3'h1);
        end
    end

    // read data always come from a register so the popped value is clean
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stk.top <= `MRX_PC_RST;
        end else if (ce && stk.push) begin
            stk.top <= stk.push_data;
        end else if (ce && stk.pop) begin
            stk.top <= mem_reg[ptr_back(ptr_reg, 3'h2)];
        end
    end
endmodule

// ==== verilog/mrx_core.sv ====
// executor for store-accumulator, load-literal, no-operation and both returns
// assumes program memory returns the word at pc in the same cycle and that
// the rest of the core pushes return addresses through push_req
`timescale 1ns/1ps
`include "mrx_defines.svh"

module mrx_core (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    input  wire logic [`MRX_WORD_W-1:0]    instr_word,
    input  wire logic                      push_req,
    input  wire logic [`MRX_PC_W-1:0]      push_addr,
    input  wire logic                      gie_clear,
    output logic      [`MRX_PC_W-1:0]      pc,
    output logic      [`MRX_DATA_W-1:0]    accumulator,
    output logic      [`MRX_DATA_W-1:0]    irq_control,
    output logic                           file_we,
    output logic      [`MRX_FADDR_W-1:0]   file_addr,
    output logic      [`MRX_DATA_W-1:0]    file_wdata,
    output logic                           second_cycle,
    output logic                           unknown_op
);
    mrx_stack_if            stk ();
    mrx_pkg::mrx_state_t    state_reg;
    mrx_pkg::mrx_op_t       op;
    logic                   run;

    mrx_stack u_stack (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .stk   (stk)
    );

    function automatic mrx_pkg::mrx_op_t decode(input logic [`MRX_WORD_W-1:0] w);
        if ((w & `MRX_OP_MOVE_MASK) == `MRX_OP_STORE_ACC) begin
            decode = mrx_pkg::MRX_OP_STORE;
        end else if ((w & `MRX_OP_LIT_MASK) == `MRX_OP_LOAD_LIT) begin
            decode = mrx_pkg::MRX_OP_LOAD;
        end else if ((w & `MRX_OP_LIT_MASK) == `MRX_OP_LIT_RET) begin
            decode = mrx_pkg::MRX_OP_LRET;
        end else if (w == `MRX_OP_IRET) begin
            decode = mrx_pkg::MRX_OP_IRET;
        end else if ((w & `MRX_OP_NOP_MASK) == `MRX_OP_NOP) begin
            decode = mrx_pkg::MRX_OP_NONE;
        end else begin
            decode = mrx_pkg::MRX_OP_OTHER;
        end
    endfunction

    function automatic logic is_return(input mrx_pkg::mrx_op_t o);
        is_return = (o == mrx_pkg::MRX_OP_IRET) || (o == mrx_pkg::MRX_OP_LRET);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode; the word fetched during the second cycle of a return is dropped
    always_comb begin
        op  = decode(instr_word);
        run = ce && (state_reg == mrx_pkg::MRX_ST_EXEC);
    end

    // return pops the stack; a return wins a clash and blocks the push from the call logic
    always_comb begin
        stk.push      = push_req && !(run && is_return(op));
        stk.push_data = push_addr;
        stk.pop       = run && is_return(op);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: returns take a second cycle, all else takes one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= mrx_pkg::MRX_ST_EXEC;
        end else if (ce) begin
            unique case (state_reg)
                mrx_pkg::MRX_ST_EXEC: begin
                    if (is_return(op)) begin
                        state_reg <= mrx_pkg::MRX_ST_SECOND;
                    end
                end
                mrx_pkg::MRX_ST_SECOND: begin
                    state_reg <= mrx_pkg::MRX_ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            second_cycle <= 1'b0;
        end else if (ce) begin
            second_cycle <= run && is_return(op);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pc <= `MRX_PC_RST;
        end else if (run) begin
            if (is_return(op)) begin
                pc <= stk.top;
            end else begin
                pc <= pc + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator; no flag is kept here, so no status can change
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            accumulator <= `MRX_ACC_RST;
        end else if (run && (op == mrx_pkg::MRX_OP_LOAD)) begin
            accumulator <= instr_word[`MRX_DATA_W-1:0];
        end else if (run && (op == mrx_pkg::MRX_OP_LRET)) begin
            accumulator <= instr_word[`MRX_DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // file register write port, one-cycle strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            file_we    <= 1'b0;
            file_addr  <= '0;
            file_wdata <= '0;
        end else if (ce) begin
            file_we <= run && (op == mrx_pkg::MRX_OP_STORE);
            if (run && (op == mrx_pkg::MRX_OP_STORE)) begin
                file_addr  <= instr_word[`MRX_FADDR_W-1:0];
                file_wdata <= accumulator;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt control: only the enable bit lives here; the set of an interrupt return
    // wins over a clear from the interrupt logic in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_control <= `MRX_IRQ_CTRL_RST;
        end else if (run && (op == mrx_pkg::MRX_OP_IRET)) begin
            irq_control[`MRX_GIE_BIT] <= 1'b1;
        end else if (ce && gie_clear) begin
            irq_control[`MRX_GIE_BIT] <= 1'b0;
        end
    end

    // words outside this group execute as no-operation and are flagged
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unknown_op <= 1'b0;
        end else if (ce) begin
            unknown_op <= run && (op == mrx_pkg::MRX_OP_OTHER);
        end
    end
endmodule

// ==== testbench/mrx_core_sva.sv ====
// concurrent checks on the move-and-return executor ports
// assumes the design clock clk and synchronous active-low rst_b
`timescale 1ns/1ps
`include "mrx_defines.svh"

module mrx_core_sva (
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   ce,
    input wire logic [`MRX_WORD_W-1:0] instr_word,
    input wire logic [`MRX_PC_W-1:0]   pc,
    input wire logic [`MRX_DATA_W-1:0] accumulator,
    input wire logic [`MRX_DATA_W-1:0] irq_control,
    input wire logic                   file_we,
    input wire logic [6:0]             file_addr,
    input wire logic [`MRX_DATA_W-1:0] file_wdata,
    input wire logic                   second_cycle,
    input wire logic                   gie_clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic go       = ce && !second_cycle;
    wire logic is_store = go && (instr_word & `MRX_OP_MOVE_MASK) == `MRX_OP_STORE_ACC;
    wire logic is_load  = go && (instr_word & `MRX_OP_LIT_MASK) == `MRX_OP_LOAD_LIT;
    wire logic is_lret  = go && (instr_word & `MRX_OP_LIT_MASK) == `MRX_OP_LIT_RET;
    wire logic is_iret  = go && instr_word == `MRX_OP_IRET;
    wire logic is_nop   = go && (instr_word & `MRX_OP_NOP_MASK) == `MRX_OP_NOP;
    ////////////////////////////////////////////////////////////////////////////
    // a return holds the core for exactly one extra enabled cycle
    sequence s_two_cycle;
        second_cycle ##1 !second_cycle;
    endsequence
    a_store_to_file: assert property (is_store |=> file_we && file_addr == $past(instr_word[6:0])
        && file_wdata == $past(accumulator)) else $error("store write wrong");
    a_store_one_word: assert property (is_store |=> $stable(accumulator) && !second_cycle
        && pc == $past(pc) + 13'h0001) else $error("store side effect");
    a_load_literal: assert property (is_load |=> accumulator == $past(instr_word[7:0])
        && !second_cycle) else $error("load literal wrong");
    a_iret_sets_gie: assert property (is_iret |=> irq_control[`MRX_GIE_BIT]
        && $stable(accumulator)) else $error("iret enable wrong");
    a_lret_literal: assert property (is_lret |=> accumulator == $past(instr_word[7:0])
        && !file_we) else $error("lret literal wrong");
    a_return_two_cyc: assert property ((is_iret || is_lret) ##1 ce |-> s_two_cycle)
        else $error("return length wrong");
    a_second_frozen: assert property (second_cycle && ce |=> $stable(pc) && $stable(accumulator))
        else $error("second cycle not idle");
    // a clear from the interrupt logic may legally land on the same edge as a no-operation
    a_nop_idle: assert property (is_nop |=> pc == $past(pc) + 13'h0001 && !file_we
        && $stable(accumulator) && ($stable(irq_control) || $past(gie_clear)))
        else $error("nop changed state");
endmodule

bind mrx_core mrx_core_sva chk (.clk(clk), .rst_b(rst_b), .ce(ce), .instr_word(instr_word),
    .pc(pc), .accumulator(accumulator), .irq_control(irq_control), .file_we(file_we),
    .file_addr(file_addr), .file_wdata(file_wdata), .second_cycle(second_cycle),
    .gie_clear(gie_clear));

// ==== testbench/mrx_prog_mem.sv ====
// program memory (same-cycle read) and file registers facing the executor
// assumes the bench loads words into mem before reset is released
`timescale 1ns/1ps

module mrx_prog_mem (
    input wire logic        clk,
    input wire logic [12:0] pc,
    output logic     [13:0] instr_word,
    input wire logic        file_we,
    input wire logic [6:0]  file_addr,
    input wire logic [7:0]  file_wdata
);
    logic [13:0] mem  [0:63] = '{default: 14'h0000};
    logic [7:0]  regs [0:127];
    // only 64 words decoded; upper pc bits alias
    assign instr_word = mem[pc[5:0]];
    always @(posedge clk) begin
        if (file_we) begin
            regs[file_addr] <= file_wdata;
        end
    end
endmodule

// ==== testbench/test_mrx_core.sv ====
// self-checking bench for the move-and-return executor
// assumes the program memory model and the bound checker
`timescale 1ns/1ps
`include "mrx_defines.svh"

module test_mrx_core;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        push_req = 1'b0;
    logic [12:0] push_addr = 13'h0000;
    logic        gie_clear = 1'b0;
    logic [13:0] instr_word;
    logic [12:0] pc;
    logic [7:0]  acc, irq, wdata;
    logic [6:0]  faddr;
    logic        we, sec, unk;
    int          fails = 0, checked = 0, cycles = 0;

    mrx_core dut (.clk(clk), .rst_b(rst_b), .ce(ce), .instr_word(instr_word),
        .push_req(push_req), .push_addr(push_addr), .gie_clear(gie_clear), .pc(pc),
        .accumulator(acc), .irq_control(irq), .file_we(we), .file_addr(faddr),
        .file_wdata(wdata), .second_cycle(sec), .unknown_op(unk));
    mrx_prog_mem rom (.clk(clk), .pc(pc), .instr_word(instr_word), .file_we(we),
        .file_addr(faddr), .file_wdata(wdata));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 200) begin
            fails++;
            print_verdict();
        end
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_moves();
        tick();
        chk({8'h00, acc}, 16'h00a5);
        tick();
        chk({we, faddr, wdata}, 16'hffa5);
        chk({8'h00, acc}, 16'h00a5);
        tick();
        chk({we, 2'h0, pc}, 16'h0003);
        chk({8'h00, rom.regs[7'h7f]}, 16'h00a5);
        tick();
        chk({acc, pc[7:0]}, 16'h0004);
        $display("test moves done");
    endtask
    task automatic test_returns();
        push_req = 1'b1;
        push_addr = 13'h0020;
        tick();
        push_addr = 13'h0010;
        tick();
        push_req = 1'b0;
        ce = 1'b0;
        tick();
        chk({3'h0, pc}, 16'h0006);
        ce = 1'b1;
        tick();
        chk({sec, 2'h0, pc}, 16'h8010);
        chk({acc, irq}, 16'h3c00);
        tick();
        chk({sec, 2'h0, pc}, 16'h0010);
        chk({8'h00, acc}, 16'h003c);
        tick();
        chk({sec, 2'h0, pc}, 16'h8020);
        chk({acc, irq}, 16'h3c80);
        tick();
        chk({sec, 2'h0, pc}, 16'h0020);
        tick();
        chk({8'h00, acc}, 16'h0011);
        gie_clear = 1'b1;
        tick();
        gie_clear = 1'b0;
        chk({irq, 3'h0, pc[4:0]}, 16'h0002);
        $display("test returns done");
    endtask
    // a word outside the group only advances pc and pulses the flag
    task automatic test_unknown();
        tick();
        chk({unk, 2'h0, pc}, 16'h8023);
        chk({acc, irq}, 16'h1100);
        tick();
        chk({unk, 2'h0, pc}, 16'h0024);
        $display("test unknown done");
    endtask
    initial begin
        rom.mem[0] = 14'h30a5;
        rom.mem[1] = 14'h00ff;
        rom.mem[3] = 14'h3300;
        rom.mem[6] = 14'h343c;
        rom.mem[16] = `MRX_OP_IRET;
        rom.mem[32] = 14'h3011;
        rom.mem[33] = 14'h0060;
        rom.mem[34] = 14'h3fff;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        test_moves();
        test_returns();
        test_unknown();
        print_verdict();
    end
endmodule
